// >>> serial_peer.sv
// Purpose: Remote serial party that sends and captures frames.
// Assumes: Bit time of 16 clocks, divisor zero.
// Notes: Samples mid-bit after the start edge, like a plain receiver.
`timescale 1ns/1ps
module serial_peer (
	input wire logic clock,
	input wire logic txd,
	output logic rxd
);
	int bt = 16;
	logic [12:0] got;
	initial rxd = 1'b1;
	task automatic send(input logic [12:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			rxd <= b[i];
			repeat (bt) @(posedge clock);
		end
		rxd <= 1'b1;
	endtask
	task automatic grab(input int n);
		int k;
		k = 0;
		while (txd !== 1'b0 && k < 5000) begin
			@(posedge clock);
			k++;
		end
		repeat (bt / 2) @(posedge clock);
		for (int i = 0; i < n; i++) begin
			got[i] = txd;
			repeat (bt) @(posedge clock);
		end
	endtask
endmodule

// >>> testbench.sv
// Purpose: Frame-format tests over the register port.
// Assumes: Divisor zero, so one bit is 16 clocks.
// Notes: A second-stop-low frame is sent last; it leaves a phantom start.
`timescale 1ns/1ps
module testbench;
	import usart_frame_pkg::*;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic [2:0] address = 3'h0;
	logic [7:0] writeData = 8'h00;
	logic writeStrobe = 1'b0;
	logic readStrobe = 1'b0;
	logic [7:0] readData, v, m8;
	logic rxd, txd, irq;
	logic [12:0] f, msk;
	logic [8:0] d;
	logic [2:0] sz;
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	int len, nb, p;
	always #5 clock = ~clock;
	usart_frame_format dut_u (.clock(clock), .rstn(rstn), .address(address),
		.writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
		.readData(readData), .rxd(rxd), .txd(txd), .irq(irq));
	serial_peer peer_u (.clock(clock), .txd(txd), .rxd(rxd));
	task automatic chk(input string s, input logic [12:0] e, input logic [12:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] x);
		address <= a;
		writeData <= x;
		writeStrobe <= 1'b1;
		@(posedge clock);
		writeStrobe <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] x);
		address <= a;
		readStrobe <= 1'b1;
		@(posedge clock);
		readStrobe <= 1'b0;
		#1 x = readData;
		@(posedge clock);
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	function automatic logic [12:0] frame(input logic [8:0] x, input int n, input int pm,
		input int s, output int l);
		logic [12:0] r;
		logic q;
		r = '1;
		r[0] = 1'b0;
		q = (pm == 3);
		for (int i = 0; i < n; i++) begin
			r[i + 1] = x[i];
			q ^= x[i];
		end
		if (pm != 0) r[n + 1] = q;
		l = n + 2 + s + int'(pm != 0);
		frame = r;
	endfunction
	// Sends one frame and checks only status bits ST_RXC, ST_FE and ST_PE
	task automatic rx_check(input logic [12:0] fr, input logic [7:0] st);
		peer_u.send(fr, len);
		repeat (8) @(posedge clock);
		rd(ADDR_STATUS, v);
		chk("rxstat", st, v & 8'h94);
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			stop_test();
		end
	end
	initial begin
		repeat (3) @(posedge clock);
		chk("rstline", {1'b1, 1'b0, 8'h00}, {txd, irq, readData});
		rstn <= 1'b1;
		@(posedge clock);
		rd(ADDR_CTRL_C, v);
		chk("ctrlC", CTRL_C_RST, v);
		rd(3'h7, v);
		chk("unmapped", 0, v);
		wr(ADDR_MASK, 8'h00);
		wr(ADDR_DIV_HIGH, 8'h00);
		wr(ADDR_DIV_LOW, 8'h00);
		chk("irqinit", 0, irq);
		for (int z = 0; z < 5; z++) for (int k = 0; k < 3; k++) for (int s = 0; s < 2; s++) begin
			sz = (z == 4) ? 3'h7 : 3'(z);
			nb = (z == 4) ? 9 : z + 5;
			p = (k == 0) ? 0 : k + 1;
			d = 9'h1A5 ^ 9'(z * 37 + k * 11 + s);
			f = frame(d, nb, p, s, len);
			msk = 13'((1 << len) - 1);
			m8 = 8'((1 << nb) - 1);
			wr(ADDR_CTRL_C, {2'b00, 2'(p), s[0], sz[1:0], 1'b0});
			wr(ADDR_CTRL_B, {3'b000, 2'b11, sz[2], 1'b0, d[8]});
			wr(ADDR_STATUS, 8'h40);
			fork
				peer_u.grab(len);
				wr(ADDR_DATA, d[7:0]);
			join
			chk("txframe", f & msk, peer_u.got & msk);
			rd(ADDR_STATUS, v);
			chk("txc", 1, v[ST_TXC]);
			peer_u.send(f, len);
			repeat (8) @(posedge clock);
			rd(ADDR_STATUS, v);
			chk("rxstat", 8'h80, v & 8'h94);
			rd(ADDR_CTRL_B, v);
			if (sz == 3'h7) chk("rx9", d[8], v[CB_RX9]);
			rd(ADDR_DATA, v);
			chk("rxdata", d[7:0] & m8, v & m8);
		end
		// Back to eight-bit size, receiver only; a buffered byte must not leave
		wr(ADDR_CTRL_B, 8'h10);
		wr(ADDR_DATA, 8'h00);
		repeat (40) @(posedge clock);
		chk("txoff", 1, txd);
		wr(ADDR_CTRL_C, 8'h2E);
		wr(ADDR_MASK, 8'h80);
		rd(ADDR_MASK, v);
		chk("mask", 8'h80, v);
		f = frame(9'h05A, 8, 2, 1, len);
		f[9] = ~f[9];
		rx_check(f, 8'h84);
		chk("irq", 1, irq);
		rd(ADDR_DATA, v);
		repeat (2) @(posedge clock);
		chk("irqclr", 0, irq);
		f = frame(9'h0C3, 8, 2, 1, len);
		f[10] = 1'b0;
		rx_check(f, 8'h90);
		rd(ADDR_DATA, v);
		f = frame(9'h0C3, 8, 2, 1, len);
		f[11] = 1'b0;
		rx_check(f, 8'h80);
		stop_test();
	end
endmodule

// >>> usart_frame_format.sv
// Purpose: Serial port with programmable frame format and register access.
// Assumes: One 100 MHz clock; software follows the setup order below.
// Notes: One frame format serves both directions; no protection of frames in flight.
// Operation
// (RQ1) All thirty combinations of one start bit, 5-9 data bits, none/even/odd parity and 1-2 stops work.
// (RQ2) A frame is the start bit then data bits least significant first, at most nine.
// (RQ3) An enabled parity bit sits after the last data bit and before the first stop bit.
// (RQ4) After the last stop bit the transmitter starts the next frame at once or idles high.
// (RQ5) Receiver and transmitter share one frame-format setting.
// (RQ6) Changing the format during traffic corrupts frames in flight, and nothing guards them.
// (RQ7) Size field sets data bits, parity field sets parity, stop select sets one or two stops.
// (RQ8) The receiver checks only the first stop bit and flags a frame error when it is low.
// (RQ9) Parity is the XOR of the data bits for even, its inverse for odd.
// (RQ10) Software sets divisor and format before enabling transmitter or receiver.
// (RQ11) Software should disable interrupts globally while setting up.
// (RQ12) Software confirms no transfer is in progress before changing rate or format.
// (RQ13) Software clears the transmit-complete flag before each data write it relies on.
// (RQ14) Size code seven selects nine bits; the ninth transmit bit comes from a control bit.
// (RQ15) The baud counter reloads at zero and on every write of the divisor low byte.
// (RQ16) Size codes 0-3 give five to eight bits; codes 4-6 are reserved.
// (RQ17) Parity code 00 is off, 10 even, 11 odd, 01 reserved.
`timescale 1ns/1ps
module usart_frame_format #(
	parameter int DIV_WIDTH = usart_frame_pkg::DIV_W
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [usart_frame_pkg::ADDR_W-1:0] address,
	input wire logic [usart_frame_pkg::DATA_W-1:0] writeData,
	input wire logic writeStrobe,
	input wire logic readStrobe,
	output logic [usart_frame_pkg::DATA_W-1:0] readData,
	input wire logic rxd,
	output logic txd,
	output logic irq
);
	import usart_frame_pkg::*;
	typedef struct packed {
		logic [7:0] ctrlB;
		logic [7:0] ctrlC;
		logic [DIV_WIDTH-1:0] divisor;
		logic [DIV_WIDTH-1:0] baudCount;
		logic [3:0] txPhase;
		logic [8:0] txBuf;
		logic txBufFull;
		logic [8:0] rxBuf;
		logic rxFe;
		logic rxPe;
		logic rxc;
		logic txc;
		logic [7:0] mask;
		logic [7:0] rdata;
		logic irq;
		logic txd;
		logic rxMeta;
		logic rxSync;
	} top_t;
	top_t s, next_s;
	logic baudTick;
	logic bitTick;
	logic [2:0] sizeSel;
	logic [1:0] parityMode;
	logic [3:0] nBits;
	logic twoStop;
	logic txBusy;
	logic txDone;
	logic txLine;
	logic rxValid;
	logic [8:0] rxWord;
	logic rxFrameErr;
	logic rxParityErr;
	logic txStart;
	logic [7:0] status;
	logic [7:0] clearBits;
	// Single shared format decode feeds both directions
	assign sizeSel = {s.ctrlB[CB_SIZE2], s.ctrlC[CC_SIZE_LO+1 -: 2]}; // RQ5 RQ14
	assign parityMode = s.ctrlC[CC_PAR_LO+1 -: 2]; // RQ17
	assign nBits = data_bits(sizeSel); // RQ16 RQ7 RQ1
	assign twoStop = s.ctrlC[CC_STOP]; // RQ7
	assign baudTick = (s.baudCount == '0);
	assign bitTick = baudTick && (s.txPhase == 4'(OVERSAMPLE - 1));
	assign txStart = s.txBufFull && !txBusy && s.ctrlB[CB_TXEN]; // RQ4
	always_comb begin
		status = 8'h00;
		status[ST_RXC] = s.rxc;
		status[ST_TXC] = s.txc;
		status[ST_TXRDY] = !s.txBufFull;
		status[ST_FE] = s.rxFe;
		status[ST_PE] = s.rxPe;
	end
	always_comb begin
		next_s = s;
		clearBits = 8'h00;
		next_s.rxMeta = rxd;
		next_s.rxSync = s.rxMeta;
		next_s.rdata = 8'h00;
		// Baud down-counter
		if (baudTick) begin
			next_s.baudCount = s.divisor; // RQ15
			next_s.txPhase = s.txPhase + 4'h1;
		end else begin
			next_s.baudCount = s.baudCount - DIV_WIDTH'(1);
		end
		if (txStart) begin
			next_s.txBufFull = 1'b0;
		end
		if (readStrobe) begin
			case (address)
				ADDR_DATA: begin
					next_s.rdata = s.rxBuf[7:0];
					next_s.rxc = 1'b0;
				end
				ADDR_STATUS: next_s.rdata = status;
				ADDR_CTRL_B: next_s.rdata = {s.ctrlB[7:2], s.rxBuf[8], s.ctrlB[CB_TX9]};
				ADDR_CTRL_C: next_s.rdata = s.ctrlC;
				ADDR_DIV_LOW: next_s.rdata = s.divisor[7:0];
				ADDR_DIV_HIGH: next_s.rdata = 8'(s.divisor[DIV_WIDTH-1:8]);
				ADDR_MASK: next_s.rdata = s.mask;
				default: next_s.rdata = 8'h00;
			endcase
		end
		if (writeStrobe) begin
			case (address)
				ADDR_DATA: begin
					// Ninth bit must already sit in control B
					next_s.txBuf = {s.ctrlB[CB_TX9], writeData}; // RQ14
					next_s.txBufFull = 1'b1;
				end
				ADDR_STATUS: clearBits = writeData;
				ADDR_CTRL_B: next_s.ctrlB = writeData;
				// Format writes act at once, frames in flight are not protected
				ADDR_CTRL_C: next_s.ctrlC = writeData; // RQ6
				ADDR_DIV_LOW: begin
					next_s.divisor[7:0] = writeData;
					next_s.baudCount = {s.divisor[DIV_WIDTH-1:8], writeData}; // RQ15
				end
				ADDR_DIV_HIGH: next_s.divisor[DIV_WIDTH-1:8] = writeData[DIV_WIDTH-9:0];
				ADDR_MASK: next_s.mask = writeData;
				default: next_s.mask = s.mask;
			endcase
		end
		if (clearBits[ST_TXC]) begin
			next_s.txc = 1'b0;
		end
		if (txDone) begin
			next_s.txc = 1'b1;
		end
		if (rxValid) begin
			next_s.rxBuf = rxWord;
			next_s.rxFe = rxFrameErr; // RQ8
			next_s.rxPe = rxParityErr;
			next_s.rxc = 1'b1;
		end
		next_s.txd = s.ctrlB[CB_TXEN] ? txLine : 1'b1; // RQ4
		// Registered, so the request trails its status bit by one cycle
		next_s.irq = |(status & s.mask & 8'hC0);
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s <= '{ctrlB: CTRL_B_RST, ctrlC: CTRL_C_RST, divisor: '0, baudCount: '0,
				txPhase: 4'h0, txBuf: 9'h000, txBufFull: 1'b0, rxBuf: 9'h000, rxFe: 1'b0,
				rxPe: 1'b0, rxc: 1'b0, txc: 1'b0, mask: 8'h00, rdata: 8'h00, irq: 1'b0,
				txd: 1'b1, rxMeta: 1'b1, rxSync: 1'b1};
		end else begin
			s <= next_s;
		end
	end
	usart_tx txUnit (
		.clock(clock),
		.rstn(rstn),
		.bitTick(bitTick),
		.load(txStart),
		.loadData(s.txBuf),
		.nBits(nBits),
		.parityMode(parityMode),
		.twoStop(twoStop),
		.busy(txBusy),
		.done(txDone),
		.txd(txLine)
	);
	usart_rx rxUnit (
		.clock(clock),
		.rstn(rstn),
		.enable(s.ctrlB[CB_RXEN]),
		.sampleTick(baudTick),
		.rxd(s.rxSync),
		.nBits(nBits),
		.parityMode(parityMode),
		.valid(rxValid),
		.rxData(rxWord),
		.frameErr(rxFrameErr),
		.parityErr(rxParityErr)
	);
	assign readData = s.rdata;
	assign txd = s.txd;
	assign irq = s.irq;
endmodule

// >>> usart_frame_format_sva.sv
// Purpose: Port-level checks for the serial frame-format port.
// Assumes: Every register write is visible on the bus; control, divisor and mask writes are mirrored here.
// Notes: Only writable control fields are shadowed.
`timescale 1ns/1ps
module usart_frame_format_chk
import usart_frame_pkg::*;
#(parameter int DIV_WIDTH = 12) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [2:0] address,
	input wire logic [7:0] writeData,
	input wire logic writeStrobe,
	input wire logic readStrobe,
	input wire logic [7:0] readData,
	input wire logic rxd,
	input wire logic txd,
	input wire logic irq
);
	logic [7:0] cb, cc, mk;
	logic [DIV_WIDTH-1:0] dv;
	int lowRun;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cb <= CTRL_B_RST;
			cc <= CTRL_C_RST;
			mk <= 8'h00;
			dv <= '0;
			lowRun <= 0;
		end else begin
			lowRun <= txd ? 0 : lowRun + 1;
			if (writeStrobe && address == ADDR_CTRL_B) cb <= writeData;
			if (writeStrobe && address == ADDR_CTRL_C) cc <= writeData;
			if (writeStrobe && address == ADDR_MASK) mk <= writeData;
			if (writeStrobe && address == ADDR_DIV_LOW) dv[7:0] <= writeData;
			if (writeStrobe && address == ADDR_DIV_HIGH) dv[DIV_WIDTH-1:8] <= writeData[DIV_WIDTH-9:0];
		end
	end
	sequence s_read(logic [2:0] a);
		readStrobe && address == a;
	endsequence
	property p_ctrl_c;
		s_read(ADDR_CTRL_C) |=> readData[5:1] == cc[5:1];
	endproperty
	a_ctrl_c: assert property (p_ctrl_c) else $error("format readback wrong");
	property p_ctrl_b;
		s_read(ADDR_CTRL_B) |=> (readData & 8'h1D) == (cb & 8'h1D);
	endproperty
	a_ctrl_b: assert property (p_ctrl_b) else $error("control readback wrong");
	property p_mask;
		s_read(ADDR_MASK) |=> readData[7:6] == mk[7:6];
	endproperty
	a_mask: assert property (p_mask) else $error("mask readback wrong");
	property p_unmapped;
		s_read(3'h7) |=> readData == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_rd_quiet;
		!readStrobe |=> readData == 8'h00;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside slot");
	property p_irq_off;
		(mk[7:6] == 2'b00) [*2] |-> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt while masked");
	// The line register follows a disable one cycle late
	property p_tx_off;
		(!cb[CB_TXEN]) [*2] |-> txd;
	endproperty
	a_tx_off: assert property (p_tx_off) else $error("line not idle high");
	// Every low stretch on the line spans whole bit times
	property p_bit_time;
		$rose(txd) |-> lowRun % (16 * (int'(dv) + 1)) == 0;
	endproperty
	a_bit_time: assert property (p_bit_time) else $error("bit time wrong");
endmodule
bind usart_frame_format usart_frame_format_chk #(.DIV_WIDTH(DIV_WIDTH)) chk_u (
	.clock(clock), .rstn(rstn), .address(address), .writeData(writeData),
	.writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
	.rxd(rxd), .txd(txd), .irq(irq));

// >>> usart_frame_pkg.sv
// Purpose: Shared constants for the serial frame-format port.
// Assumes: 100 MHz system clock, plain register port with 8-bit data.
// Notes: Register offsets are local choices; see the control block.
package usart_frame_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int DIV_W = 12;
	localparam int OVERSAMPLE = 16;
	localparam int SAMPLE_MID = 7;
	localparam logic [2:0] ADDR_DATA = 3'h0;
	localparam logic [2:0] ADDR_STATUS = 3'h1;
	localparam logic [2:0] ADDR_CTRL_B = 3'h2;
	localparam logic [2:0] ADDR_CTRL_C = 3'h3;
	localparam logic [2:0] ADDR_DIV_LOW = 3'h4;
	localparam logic [2:0] ADDR_DIV_HIGH = 3'h5;
	localparam logic [2:0] ADDR_MASK = 3'h6;
	localparam int CB_TXEN = 3;
	localparam int CB_RXEN = 4;
	localparam int CB_SIZE2 = 2;
	localparam int CB_TX9 = 0;
	localparam int CB_RX9 = 1;
	localparam int CC_SIZE_LO = 1;
	localparam int CC_STOP = 3;
	localparam int CC_PAR_LO = 4;
	localparam int ST_RXC = 7;
	localparam int ST_TXC = 6;
	localparam int ST_FE = 4;
	localparam int ST_PE = 2;
	localparam int ST_TXRDY = 5;
	localparam logic [7:0] CTRL_B_RST = 8'h00;
	localparam logic [7:0] CTRL_C_RST = 8'h06;
	localparam logic [1:0] PAR_OFF = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h2;
	localparam logic [1:0] PAR_ODD = 2'h3;
	localparam logic [2:0] SIZE_NINE = 3'h7;
	typedef enum logic [2:0] {
		SER_IDLE = 3'b000,
		SER_START = 3'b001,
		SER_DATA = 3'b011,
		SER_PARITY = 3'b010,
		SER_STOP1 = 3'b110,
		SER_STOP2 = 3'b111
	} ser_state_t;
	// Data-bit count for a size code; reserved codes fall back to eight bits.
	function automatic logic [3:0] data_bits(input logic [2:0] sizeSel);
		case (sizeSel)
			3'h0: data_bits = 4'h5;
			3'h1: data_bits = 4'h6;
			3'h2: data_bits = 4'h7;
			3'h7: data_bits = 4'h9;
			default: data_bits = 4'h8;
		endcase
	endfunction
	// Parity over the active data bits; odd mode inverts.
	function automatic logic parity_of(input logic [8:0] d, input logic [3:0] n,
		input logic odd);
		logic p;
		p = odd;
		for (int i = 0; i < 9; i++) begin
			if (i < int'(n)) begin
				p = p ^ d[i];
			end
		end
		parity_of = p;
	endfunction
endpackage

// >>> usart_rx.sv
// Purpose: Frame receiver with 16x oversampling.
// Assumes: rxd already synchronised; sampleTick at 16x bit rate.
// Notes: Only the first stop bit is checked.
`timescale 1ns/1ps
module usart_rx (
	input wire logic clock,
	input wire logic rstn,
	input wire logic enable,
	input wire logic sampleTick,
	input wire logic rxd,
	input wire logic [3:0] nBits,
	input wire logic [1:0] parityMode,
	output logic valid,
	output logic [8:0] rxData,
	output logic frameErr,
	output logic parityErr
);
	import usart_frame_pkg::*;
	typedef struct packed {
		ser_state_t st;
		logic [3:0] phase;
		logic [3:0] cnt;
		logic [8:0] shift;
		logic perr;
		logic valid;
		logic ferr;
	} rx_t;
	rx_t r, next_r;
	logic mid;
	always_comb begin
		next_r = r;
		next_r.valid = 1'b0;
		mid = sampleTick && (r.phase == 4'(SAMPLE_MID));
		if (sampleTick) begin
			next_r.phase = r.phase + 4'h1;
		end
		case (r.st)
			SER_IDLE: begin
				next_r.phase = 4'h0;
				if (enable && !rxd) begin
					next_r.st = SER_START;
				end
			end
			SER_START: if (mid) begin
				next_r.st = rxd ? SER_IDLE : SER_DATA;
				next_r.cnt = 4'h0;
				next_r.shift = 9'h000;
			end
			SER_DATA: if (mid) begin
				next_r.shift[r.cnt] = rxd; // RQ2
				next_r.cnt = r.cnt + 4'h1;
				if (r.cnt + 4'h1 == nBits) begin
					next_r.st = (parityMode[1]) ? SER_PARITY : SER_STOP1; // RQ3
				end
			end
			SER_PARITY: if (mid) begin
				next_r.perr = rxd ^ parity_of(r.shift, nBits, parityMode[0]); // RQ9
				next_r.st = SER_STOP1;
			end
			SER_STOP1: if (mid) begin
				next_r.ferr = !rxd; // RQ8
				if (!parityMode[1]) begin
					next_r.perr = 1'b0;
				end
				next_r.valid = 1'b1;
				next_r.st = SER_IDLE; // RQ8
			end
			default: next_r.st = SER_IDLE;
		endcase
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			r <= '{st: SER_IDLE, phase: 4'h0, cnt: 4'h0, shift: 9'h000, perr: 1'b0,
				valid: 1'b0, ferr: 1'b0};
		end else begin
			r <= next_r;
		end
	end
	assign valid = r.valid;
	assign rxData = r.shift;
	assign frameErr = r.ferr;
	assign parityErr = r.perr;
endmodule

// >>> usart_tx.sv
// Purpose: Frame transmitter.
// Assumes: One tick per bit time from the baud logic.
// Notes: Format inputs are sampled live; changing them mid-frame corrupts it.
`timescale 1ns/1ps
module usart_tx (
	input wire logic clock,
	input wire logic rstn,
	input wire logic bitTick,
	input wire logic load,
	input wire logic [8:0] loadData,
	input wire logic [3:0] nBits,
	input wire logic [1:0] parityMode,
	input wire logic twoStop,
	output logic busy,
	output logic done,
	output logic txd
);
	import usart_frame_pkg::*;
	typedef struct packed {
		ser_state_t st;
		logic [8:0] shift;
		logic [3:0] cnt;
		logic par;
		logic line;
		logic done;
	} tx_t;
	tx_t r, next_r;
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		case (r.st)
			SER_IDLE: begin
				next_r.line = 1'b1;
				if (load) begin
					next_r.shift = loadData;
					next_r.par = parity_of(loadData, nBits, parityMode[0]); // RQ9
					next_r.st = SER_START;
				end
			end
			SER_START: if (bitTick) begin
				next_r.line = 1'b0;
				next_r.cnt = 4'h0;
				next_r.st = SER_DATA; // RQ2
			end
			SER_DATA: if (bitTick) begin
				next_r.line = r.shift[0]; // RQ2
				next_r.shift = {1'b0, r.shift[8:1]};
				next_r.cnt = r.cnt + 4'h1;
				if (r.cnt + 4'h1 == nBits) begin
					next_r.st = (parityMode[1]) ? SER_PARITY : SER_STOP1; // RQ3
				end
			end
			SER_PARITY: if (bitTick) begin
				next_r.line = r.par; // RQ3
				next_r.st = SER_STOP1;
			end
			SER_STOP1: if (bitTick) begin
				next_r.line = 1'b1;
				next_r.st = twoStop ? SER_STOP2 : SER_IDLE; // RQ7
				next_r.done = !twoStop;
			end
			SER_STOP2: if (bitTick) begin
				next_r.line = 1'b1;
				next_r.st = SER_IDLE; // RQ4
				next_r.done = 1'b1;
			end
			default: next_r.st = SER_IDLE;
		endcase
	end
	// The start state waits for the next tick, so a stop level before a new frame lasts a full bit.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			r <= '{st: SER_IDLE, shift: 9'h000, cnt: 4'h0, par: 1'b0, line: 1'b1, done: 1'b0};
		end else begin
			r <= next_r;
		end
	end
	assign busy = (r.st != SER_IDLE);
	assign done = r.done;
	assign txd = r.line;
endmodule
